// ==== rtl/mgp_engine.sv ====
// Centered PWM engine with dead time, polarity, modulation modes and AXI4-Lite registers
// Functional notes
// - Reset leaves mode zero, all gates inactive
// - Mode seven selects centered modulation
// - Polarity bit one inverts high-side gates
// - Polarity bit zero inverts low-side gates
// - Eight gate outputs, four half bridges
// - Three-phase uses three bridges, stepper four
// - DC drives bridges a, b only
// - Frequency follows half clock over period plus one
// - Period count resets to 3999
// - Period count writable while running
// - Duty 12-bit resolution mapped to 16-bit
// - Symmetrical counter sets smallest pulse step
// - Resolution scales with period count
// - Passive braking and freewheel modes offered
// - Separate high-side and low-side dead times
// - Dead time in 10 ns steps, zero allowed
// - One bit enables space vector, off at reset
// - Duty is signed phase plus 0x8000
// - Debug select 0x11/0x12 reads duty values
// - Low bridge of coil takes negated value
// - Space vector subtracts midpoint, scales two/root-three
// - Mask selects flags driving status output
// - Flag bit zero set on limiter clipping
// - Flags writable whole, no single-bit clear
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module mgp_engine (
   // Clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // AXI4-Lite write
   input  wire logic [mgp_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   // AXI4-Lite read
   input  wire logic [mgp_pkg::ADDR_W-1:0] araddr,
   input  wire logic                      arvalid,
   output logic                           arready,
   output logic [31:0]                    rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  wire logic                      rready,
   // Limiter clip indication, asynchronous pin
   input  wire logic                      limiter_clip,
   // Gate drivers and status
   output mgp_pkg::mgp_gates_t            gates,
   output logic                           status_out
);
   import mgp_pkg::*;

   logic [2:0]         mode_ff;
   logic [1:0]         pol_ff;
   logic [15:0]        per_ff;
   logic [7:0]         dth_ff;
   logic [7:0]         dtl_ff;
   logic               svm_ff;
   logic [1:0]         cfg_ff;
   logic signed [15:0] pha_ff, phb_ff, phc_ff;
   logic [7:0]         dsel_ff;
   logic [31:0]        flag_ff;
   logic [31:0]        mask_ff;
   logic [15:0]        cnt_ff;
   logic               up_ff;
   logic               clip_s1_ff, clip_s2_ff;
   logic               aw_v_ff, w_v_ff;
   logic [ADDR_W-1:0]  aw_a_ff;
   logic [31:0]        w_d_ff;
   logic [3:0]         w_s_ff;
   logic               awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0]         bresp_ff, rresp_ff;
   logic [31:0]        rdata_ff;
   mgp_gates_t         gates_ff;
   logic               status_ff;
   logic               nxt_aw_v, nxt_w_v, nxt_rv, do_wr;
   logic [32:0]        wr_old, rd_val;
   logic [31:0]        bmask, wval;
   logic signed [15:0] sv [4];
   logic [3:0]         en;
   logic [15:0]        duty [4];
   logic [3:0]         raw_h, raw_l, nxt_h, nxt_l, h_ff, l_ff;
   logic [7:0]         dth_cyc, dtl_cyc;

   assign awready    = awready_ff;
   assign wready     = wready_ff;
   assign bvalid     = bvalid_ff;
   assign bresp      = bresp_ff;
   assign arready    = arready_ff;
   assign rvalid     = rvalid_ff;
   assign rresp      = rresp_ff;
   assign rdata      = rdata_ff;
   assign gates      = gates_ff;
   assign status_out = status_ff;

   // Register read mux; bit 32 flags a mapped address
   function automatic logic [32:0] rd_f(input logic [ADDR_W-1:0] a);
      logic [32:0] r;
      r = {1'b1, 32'h0000_0000};
      if (a == OFS_MODE) begin
         r[2:0] = mode_ff;
      end else if (a == OFS_POL) begin
         r[1:0] = pol_ff;
      end else if (a == OFS_PER) begin
         r[15:0] = per_ff;
      end else if (a == OFS_DTH) begin
         r[7:0] = dth_ff;
      end else if (a == OFS_DTL) begin
         r[7:0] = dtl_ff;
      end else if (a == OFS_SVM) begin
         r[0] = svm_ff;
      end else if (a == OFS_CFG) begin
         r[1:0] = cfg_ff;
      end else if (a == OFS_PHA) begin
         r[15:0] = pha_ff;
      end else if (a == OFS_PHB) begin
         r[15:0] = phb_ff;
      end else if (a == OFS_PHC) begin
         r[15:0] = phc_ff;
      end else if (a == OFS_DSEL) begin
         r[7:0] = dsel_ff;
      end else if (a == OFS_DVAL) begin
         if (dsel_ff == DBG_DUTY_A) begin
            r[15:0] = duty[0];
         end else if (dsel_ff == DBG_DUTY_B) begin
            r[15:0] = duty[1];
         end
      end else if (a == OFS_FLAG) begin
         r[31:0] = flag_ff;
      end else if (a == OFS_MASK) begin
         r[31:0] = mask_ff;
      end else if (a == OFS_CNT) begin
         r[15:0] = cnt_ff;
      end else begin
         r = 33'h0_0000_0000;
      end
      return r;
   endfunction

   // Write channel: address and data are held independently until both arrive
   assign do_wr  = aw_v_ff & w_v_ff & ~bvalid_ff;
   // A plain assign would not re-run when a register behind the mux changes
   always_comb begin
      wr_old = rd_f(aw_a_ff);
      rd_val = rd_f(araddr);
   end
   assign bmask  = {{8{w_s_ff[3]}}, {8{w_s_ff[2]}}, {8{w_s_ff[1]}}, {8{w_s_ff[0]}}};
   assign wval   = (wr_old[31:0] & ~bmask) | (w_d_ff & bmask);

   always_comb begin
      nxt_aw_v = do_wr ? 1'b0 : (aw_v_ff | (awvalid & awready_ff));
      nxt_w_v  = do_wr ? 1'b0 : (w_v_ff | (wvalid & wready_ff));
      nxt_rv   = rvalid_ff ? ~rready : (arvalid & arready_ff);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_v_ff    <= 1'b0;
         w_v_ff     <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         aw_a_ff    <= '0;
         w_d_ff     <= 32'h0000_0000;
         w_s_ff     <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OK;
      end else begin
         aw_v_ff    <= nxt_aw_v;
         w_v_ff     <= nxt_w_v;
         awready_ff <= ~nxt_aw_v;
         wready_ff  <= ~nxt_w_v;
         if (awvalid && awready_ff) begin
            aw_a_ff <= awaddr;
         end
         if (wvalid && wready_ff) begin
            w_d_ff <= wdata;
            w_s_ff <= wstrb;
         end
         if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_old[32] ? RESP_OK : RESP_ERR;
         end else if (bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Read channel: one outstanding read, answer one cycle after acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= RESP_OK;
      end else begin
         arready_ff <= ~nxt_rv;
         rvalid_ff  <= nxt_rv;
         if (arvalid && arready_ff) begin
            rdata_ff <= rd_val[31:0];
            rresp_ff <= rd_val[32] ? RESP_OK : RESP_ERR;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff <= MODE_OFF;
         pol_ff  <= 2'h0;
         per_ff  <= PER_RST;
         dth_ff  <= DT_RST;
         dtl_ff  <= DT_RST;
         svm_ff  <= 1'b0;
         cfg_ff  <= CFG_THREE;
         pha_ff  <= 16'sh0000;
         phb_ff  <= 16'sh0000;
         phc_ff  <= 16'sh0000;
         dsel_ff <= 8'h00;
         mask_ff <= MASK_RST;
      end else if (do_wr) begin
         if (aw_a_ff == OFS_MODE) begin
            mode_ff <= wval[2:0];
         end else if (aw_a_ff == OFS_POL) begin
            pol_ff <= wval[1:0];
         end else if (aw_a_ff == OFS_PER) begin
            per_ff <= wval[15:0];
         end else if (aw_a_ff == OFS_DTH) begin
            dth_ff <= wval[7:0];
         end else if (aw_a_ff == OFS_DTL) begin
            dtl_ff <= wval[7:0];
         end else if (aw_a_ff == OFS_SVM) begin
            svm_ff <= wval[0];
         end else if (aw_a_ff == OFS_CFG) begin
            cfg_ff <= wval[1:0];
         end else if (aw_a_ff == OFS_PHA) begin
            pha_ff <= wval[15:0];
         end else if (aw_a_ff == OFS_PHB) begin
            phb_ff <= wval[15:0];
         end else if (aw_a_ff == OFS_PHC) begin
            phc_ff <= wval[15:0];
         end else if (aw_a_ff == OFS_DSEL) begin
            dsel_ff <= wval[7:0];
         end else if (aw_a_ff == OFS_MASK) begin
            mask_ff <= wval;
         end
      end
   end

   // Clip pin synchroniser and status flags; the hardware set beats a software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clip_s1_ff <= 1'b0;
         clip_s2_ff <= 1'b0;
         flag_ff    <= 32'h0000_0000;
         status_ff  <= 1'b0;
      end else begin
         clip_s1_ff <= limiter_clip;
         clip_s2_ff <= clip_s1_ff;
         if (do_wr && aw_a_ff == OFS_FLAG) begin
            flag_ff <= {wval[31:1], wval[0] | clip_s2_ff};
         end else begin
            flag_ff[0] <= flag_ff[0] | clip_s2_ff;
         end
         status_ff <= |(flag_ff & mask_ff);
      end
   end

   // Triangle counter; a lowered period pulls the count back at once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 16'h0000;
         up_ff  <= 1'b1;
      end else if (cnt_ff > per_ff) begin
         cnt_ff <= per_ff;
         up_ff  <= 1'b0;
      end else if (up_ff) begin
         if (cnt_ff == per_ff) begin
            up_ff <= 1'b0;
         end else begin
            cnt_ff <= cnt_ff + 16'h0001;
         end
      end else if (cnt_ff == 16'h0000) begin
         up_ff <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff - 16'h0001;
      end
   end

   function automatic logic signed [15:0] neg_f(input logic signed [15:0] x);
      return (x == 16'sh8000) ? 16'sh7FFF : -x;
   endfunction

   // Midpoint removal and two over root three gain, saturated to 16 bits
   function automatic logic signed [15:0] svm_f(input logic signed [15:0] v,
                                                input logic signed [16:0] mid);
      logic signed [17:0] d;
      logic signed [34:0] p;
      d = {{2{v[15]}}, v} - {mid[16], mid};
      p = (d * $signed(SVM_GAIN)) >>> 15;
      if (p > 35'sh0_0000_7FFF) begin
         return 16'sh7FFF;
      end else if (p < -35'sh0_0000_8000) begin
         return 16'sh8000;
      end
      return p[15:0];
   endfunction

   logic signed [15:0] ph_max, ph_min;
   logic signed [16:0] ph_sum, ph_mid;

   always_comb begin
      ph_max = (pha_ff > phb_ff) ? pha_ff : phb_ff;
      ph_max = (phc_ff > ph_max) ? phc_ff : ph_max;
      ph_min = (pha_ff < phb_ff) ? pha_ff : phb_ff;
      ph_min = (phc_ff < ph_min) ? phc_ff : ph_min;
      ph_sum = {ph_max[15], ph_max} + {ph_min[15], ph_min};
      ph_mid = ph_sum >>> 1;
   end

   // Bridge values per motor configuration
   always_comb begin
      sv[0] = pha_ff;
      sv[1] = neg_f(pha_ff);
      sv[2] = phb_ff;
      sv[3] = neg_f(phb_ff);
      en    = 4'h0;
      if (cfg_ff == CFG_THREE) begin
         en    = 4'h7;
         sv[1] = phb_ff;
         sv[2] = phc_ff;
         if (svm_ff) begin
            sv[0] = svm_f(pha_ff, ph_mid);
            sv[1] = svm_f(phb_ff, ph_mid);
            sv[2] = svm_f(phc_ff, ph_mid);
         end
      end else if (cfg_ff == CFG_STEP) begin
         en = 4'hF;
      end else if (cfg_ff == CFG_DC) begin
         en = 4'h3;
      end
   end

   function automatic logic [7:0] dt_cyc_f(input logic [7:0] v);
      logic [15:0] t;
      t = ({8'h00, v} * DT_STEP_NS + CLK_NS - 16'h0001) / CLK_NS;
      return t[7:0];
   endfunction

   assign dth_cyc = dt_cyc_f(dth_ff);
   assign dtl_cyc = dt_cyc_f(dtl_ff);

   // Per bridge: duty, compare, mode gating and dead time
   for (genvar i = 0; i < 4; i++) begin : g_br
      logic [32:0] prod;
      logic [7:0]  hc_ff, lc_ff;
      assign duty[i] = sv[i] + DUTY_OFS;
      assign prod    = duty[i] * {1'b0, per_ff} + duty[i];

      always_comb begin
         raw_h[i] = 1'b0;
         raw_l[i] = 1'b0;
         case (mode_ff)
            MODE_CENTER: begin
               raw_h[i] = en[i] & ({1'b0, cnt_ff} < prod[32:16]);
               raw_l[i] = en[i] & ~raw_h[i];
            end
            MODE_BRAKE: begin
               raw_l[i] = en[i];
            end
            default: begin
               raw_h[i] = 1'b0;
            end
         endcase
         nxt_h[i] = raw_h[i] & ~l_ff[i] & (hc_ff >= dth_cyc);
         nxt_l[i] = raw_l[i] & ~h_ff[i] & (lc_ff >= dtl_cyc);
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            hc_ff   <= 8'h00;
            lc_ff   <= 8'h00;
            h_ff[i] <= 1'b0;
            l_ff[i] <= 1'b0;
         end else begin
            h_ff[i] <= nxt_h[i];
            l_ff[i] <= nxt_l[i];
            hc_ff   <= (raw_h[i] & ~l_ff[i]) ? hc_ff + {7'h00, hc_ff != 8'hFF} : 8'h00;
            lc_ff   <= (raw_l[i] & ~h_ff[i]) ? lc_ff + {7'h00, lc_ff != 8'hFF} : 8'h00;
         end
      end

      property p_no_overlap;
         @(posedge aclk) disable iff (!aresetn) !(h_ff[i] && l_ff[i]);
      endproperty
      a_no_overlap: assert property (p_no_overlap)
         else $error("both gates of one bridge active");
   end

   // Output polarity applied in the output flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gates_ff <= '0;
      end else begin
         gates_ff.high <= nxt_h ^ {4{pol_ff[1]}};
         gates_ff.low  <= nxt_l ^ {4{pol_ff[0]}};
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_off_held;
      (mode_ff == MODE_OFF) [*2];
   endsequence
   sequence s_clip_seen;
      clip_s2_ff ##1 flag_ff[0];
   endsequence

   property p_rst_state;
      $past(!aresetn) |-> mode_ff == MODE_OFF && per_ff == PER_RST && !svm_ff;
   endproperty
   a_rst_state: assert property (p_rst_state)
      else $error("reset state wrong");

   property p_off_gates;
      s_off_held |-> gates_ff.high == {4{$past(pol_ff[1])}} &&
                     gates_ff.low == {4{$past(pol_ff[0])}};
   endproperty
   a_off_gates: assert property (p_off_gates)
      else $error("gates active in off mode");

   property p_dc_unused;
      (cfg_ff == CFG_DC) [*2] |-> gates_ff.high[3:2] == {2{$past(pol_ff[1])}} &&
                                  gates_ff.low[3:2] == {2{$past(pol_ff[0])}};
   endproperty
   a_dc_unused: assert property (p_dc_unused)
      else $error("unused bridge driven in dc config");

   property p_cnt_bound;
      per_ff == $past(per_ff) |-> cnt_ff <= per_ff;
   endproperty
   a_cnt_bound: assert property (p_cnt_bound)
      else $error("counter above period");

   property p_clip_flag;
      clip_s2_ff |-> s_clip_seen;
   endproperty
   a_clip_flag: assert property (p_clip_flag)
      else $error("clip flag not set");

   property p_status;
      ##1 status_ff == $past(|(flag_ff & mask_ff));
   endproperty
   a_status: assert property (p_status)
      else $error("status output mismatch");

   property p_duty_plain;
      cfg_ff != CFG_THREE || !svm_ff |-> duty[0] == pha_ff + DUTY_OFS;
   endproperty
   a_duty_plain: assert property (p_duty_plain)
      else $error("duty offset wrong");

   property p_low_neg;
      cfg_ff == CFG_DC && pha_ff != 16'sh8000 |-> duty[1] == DUTY_OFS - pha_ff;
   endproperty
   a_low_neg: assert property (p_low_neg)
      else $error("low bridge value not negated");

   property p_dead_high;
      $rose(h_ff[0]) && dth_ff == DT_RST |-> !l_ff[0] && $past(!l_ff[0]);
   endproperty
   a_dead_high: assert property (p_dead_high)
      else $error("high gate rose against low gate");
endmodule // mgp_engine

// ==== rtl/mgp_pkg.sv ====
// Constants, types and register map of the gate PWM engine
package mgp_pkg;
   // Register bus
   localparam int          ADDR_W   = 8;
   localparam logic [7:0]  OFS_MODE = 8'h00;
   localparam logic [7:0]  OFS_POL  = 8'h04;
   localparam logic [7:0]  OFS_PER  = 8'h08;
   localparam logic [7:0]  OFS_DTH  = 8'h0C;
   localparam logic [7:0]  OFS_DTL  = 8'h10;
   localparam logic [7:0]  OFS_SVM  = 8'h14;
   localparam logic [7:0]  OFS_CFG  = 8'h18;
   localparam logic [7:0]  OFS_PHA  = 8'h1C;
   localparam logic [7:0]  OFS_PHB  = 8'h20;
   localparam logic [7:0]  OFS_PHC  = 8'h24;
   localparam logic [7:0]  OFS_DSEL = 8'h28;
   localparam logic [7:0]  OFS_DVAL = 8'h2C;
   localparam logic [7:0]  OFS_FLAG = 8'h30;
   localparam logic [7:0]  OFS_MASK = 8'h34;
   localparam logic [7:0]  OFS_CNT  = 8'h38;
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;
   // Reset values
   localparam logic [15:0] PER_RST  = 16'h0F9F;
   localparam logic [7:0]  DT_RST   = 8'h00;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   // Conversion constants and debug select codes
   localparam logic [15:0] DUTY_OFS = 16'h8000;
   localparam logic [16:0] SVM_GAIN = 17'h093CD;
   localparam logic [7:0]  DBG_DUTY_A = 8'h11;
   localparam logic [7:0]  DBG_DUTY_B = 8'h12;
   // Timing: dead time step and clock period in ns
   localparam logic [15:0] DT_STEP_NS = 16'h000A;
   localparam logic [15:0] CLK_NS     = 16'h0019;
   // Output modes
   typedef enum logic [2:0] {
      MODE_OFF    = 3'b000,
      MODE_BRAKE  = 3'b101,
      MODE_FREE   = 3'b110,
      MODE_CENTER = 3'b111
   } mgp_mode_t;
   // Motor configurations
   typedef enum logic [1:0] {
      CFG_THREE = 2'b00,
      CFG_STEP  = 2'b01,
      CFG_DC    = 2'b10
   } mgp_cfg_t;
   // Gate outputs of four half bridges, index 0..3 is bridge a..d
   typedef struct packed {
      logic [3:0] high;
      logic [3:0] low;
   } mgp_gates_t;
endpackage

// ==== tb/mgp_gate_model.sv ====
// Behavioural power stage model that counts cycles with shoot-through on any half bridge, one total
`timescale 1ns/1ps
module mgp_gate_model
   import mgp_pkg::*;
(
   // Clock
   input  wire logic                aclk,
   // Gate drive from the engine, four half bridges
   input  wire mgp_pkg::mgp_gates_t gates,
   // Cycles with both switches of one bridge on
   output logic [15:0]              overlaps
);
   initial overlaps = 16'h0000;

   // Only valid while both polarity bits are clear; the bench never sets both together
   always @(posedge aclk) begin
      if ((gates.high & gates.low) != 4'h0) begin
         overlaps <= overlaps + 16'h0001;
      end
   end
endmodule // mgp_gate_model

// ==== tb/tb_top.sv ====
// Self-checking bench of the gate PWM engine
`timescale 1ns/1ps
module tb_top;
   import mgp_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, limiter_clip;
   logic        awready, wready, bvalid, arready, rvalid, status_out;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] overlaps;
   mgp_gates_t  gates;
   int          fails, total_checks, cyc, h, o, r, u;

   mgp_engine dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .limiter_clip(limiter_clip), .gates(gates), .status_out(status_out));
   mgp_gate_model drv_u (.aclk(aclk), .gates(gates), .overlaps(overlaps));

   always #12.5 aclk = ~aclk;

   task automatic test_done();
      if (fails == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic rng(input int v, input int lo, input int hi, input string m);
      total_checks++;
      if (v < lo || v > hi) begin
         fails++;
         $display("Error at %0t: %s count %0d outside %0d..%0d", $time, m, v, lo, hi);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad;
      logic dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!dd && wready === 1'b1) begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er}, "bresp");
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
      rd = rdata;
      chk({30'h0, rresp}, {30'h0, er}, "rresp");
      chk(rd, exp, "read data");
   endtask

   // Bridge a high time, both-off time, high rises, and activity on bridges c and d
   task automatic meas(input int n);
      logic prev;
      h = 0;
      o = 0;
      r = 0;
      u = 0;
      prev = gates.high[0];
      repeat (n) begin
         @(negedge aclk);
         if (gates.high[0] === 1'b1) h++;
         if ((gates.high[0] | gates.low[0]) === 1'b0) o++;
         if (gates.high[0] === 1'b1 && prev === 1'b0) r++;
         if ({gates.high[3:2], gates.low[3:2]} !== 4'h0) u++;
         prev = gates.high[0];
      end
   endtask

   task automatic t_reset();
      rdc(OFS_MODE, 32'h0, RESP_OK);
      rdc(OFS_PER, 32'h0000_0F9F, RESP_OK);
      rdc(OFS_DTH, 32'h0, RESP_OK);
      rdc(OFS_DTL, 32'h0, RESP_OK);
      rdc(OFS_SVM, 32'h0, RESP_OK);
      rdc(OFS_MASK, 32'h0, RESP_OK);
      chk({24'h0, gates}, 32'h0, "gates idle");
   endtask

   task automatic t_unmapped();
      wr(8'h3C, 32'h0000_00A5, RESP_ERR);
      rdc(8'h3C, 32'h0, RESP_ERR);
   endtask

   task automatic t_pol();
      wr(OFS_POL, 32'h2, RESP_OK);
      repeat (4) @(posedge aclk);
      chk({26'h0, gates.high[2:0], gates.low[2:0]}, 32'h38, "high inverted");
      wr(OFS_POL, 32'h1, RESP_OK);
      repeat (4) @(posedge aclk);
      chk({26'h0, gates.high[2:0], gates.low[2:0]}, 32'h07, "low inverted");
      wr(OFS_POL, 32'h0, RESP_OK);
   endtask

   task automatic t_duty();
      wr(OFS_PHA, 32'h0000_1234, RESP_OK);
      wr(OFS_PHB, 32'h0000_FF00, RESP_OK);
      wr(OFS_DSEL, {24'h0, DBG_DUTY_A}, RESP_OK);
      rdc(OFS_DVAL, 32'h0000_9234, RESP_OK);
      wr(OFS_DSEL, {24'h0, DBG_DUTY_B}, RESP_OK);
      rdc(OFS_DVAL, 32'h0000_7F00, RESP_OK);
      wr(OFS_CFG, 32'h1, RESP_OK);
      rdc(OFS_DVAL, 32'h0000_6DCC, RESP_OK);
      // Max 4096, min -2048: midpoint 1024 is removed before the gain
      wr(OFS_CFG, 32'h0, RESP_OK);
      wr(OFS_PHA, 32'h0000_1000, RESP_OK);
      wr(OFS_PHB, 32'h0000_0800, RESP_OK);
      wr(OFS_PHC, 32'h0000_F800, RESP_OK);
      wr(OFS_SVM, 32'h1, RESP_OK);
      rdc(OFS_SVM, 32'h1, RESP_OK);
      rdc(OFS_DVAL, 32'h0000_849E, RESP_OK);
      wr(OFS_DSEL, {24'h0, DBG_DUTY_A}, RESP_OK);
      rdc(OFS_DVAL, 32'h0000_8DDB, RESP_OK);
      wr(OFS_SVM, 32'h0, RESP_OK);
   endtask

   task automatic t_run();
      wr(OFS_CFG, 32'h2, RESP_OK);
      wr(OFS_PHA, 32'h0, RESP_OK);
      wr(OFS_PER, 32'd99, RESP_OK);
      wr(OFS_MODE, 32'h7, RESP_OK);
      repeat (8) @(posedge aclk);
      meas(792);
      rng(h, 380, 400, "half duty high time");
      rng(u, 0, 0, "unused bridges");
      wr(OFS_DTH, 32'd50, RESP_OK);
      wr(OFS_DTL, 32'd50, RESP_OK);
      repeat (8) @(posedge aclk);
      meas(792);
      rng(o, 140, 792, "dead time gaps");
      wr(OFS_CFG, 32'h1, RESP_OK);
      wr(OFS_PER, 32'd49, RESP_OK);
      repeat (8) @(posedge aclk);
      meas(980);
      rng(r, 9, 11, "periods after change");
      rng(u, 1, 980, "stepper bridges c d");
      wr(OFS_CFG, 32'h2, RESP_OK);
      wr(OFS_MODE, 32'h5, RESP_OK);
      repeat (40) @(posedge aclk);
      chk({24'h0, gates}, 32'h03, "brake");
      wr(OFS_MODE, 32'h6, RESP_OK);
      repeat (40) @(posedge aclk);
      chk({24'h0, gates}, 32'h0, "freewheel");
      chk({16'h0, overlaps}, 32'h0, "shoot-through");
   endtask

   task automatic t_flags();
      limiter_clip <= 1'b1;
      repeat (6) @(posedge aclk);
      limiter_clip <= 1'b0;
      rdc(OFS_FLAG, 32'h1, RESP_OK);
      chk({31'h0, status_out}, 32'h0, "status masked");
      wr(OFS_MASK, 32'h1, RESP_OK);
      repeat (3) @(posedge aclk);
      chk({31'h0, status_out}, 32'h1, "status on");
      wr(OFS_FLAG, 32'h0, RESP_OK);
      repeat (3) @(posedge aclk);
      rdc(OFS_FLAG, 32'h0, RESP_OK);
      chk({31'h0, status_out}, 32'h0, "status off");
   endtask

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, limiter_clip} = 6'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      fails = 0;
      total_checks = 0;
      cyc = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset();
      t_unmapped();
      t_pol();
      t_duty();
      t_run();
      t_flags();
      test_done();
   end
endmodule // tb_top
